// file: hdl/tmc_defines.vh
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH
// register byte offsets
`define TMC_OFS_CTRL_A  12'h000
`define TMC_OFS_CTRL_B  12'h004
`define TMC_OFS_COUNT   12'h008
`define TMC_OFS_CMP_A   12'h00C
`define TMC_OFS_CMP_B   12'h010
`define TMC_OFS_MASK    12'h014
`define TMC_OFS_FLAGS   12'h018
// field positions
`define TMC_COM_A_HI    7
`define TMC_COM_A_LO    6
`define TMC_COM_B_HI    5
`define TMC_COM_B_LO    4
`define TMC_WGM_HI      1
`define TMC_WGM_LO      0
`define TMC_WGM2_BIT    3
`define TMC_CS_HI       2
`define TMC_CS_LO       0
`define TMC_BIT_OVF     0
`define TMC_BIT_CMPA    1
`define TMC_BIT_CMPB    2
// reset values
`define TMC_RST_BYTE    8'h00
`define TMC_RST_FLAGS   3'h0
// tick source select codes
`define TMC_CS_STOP     3'h0
`define TMC_CS_DIV1     3'h1
`define TMC_CS_DIV8     3'h2
`define TMC_CS_DIV64    3'h3
`define TMC_CS_DIV256   3'h4
`define TMC_CS_DIV1024  3'h5
`define TMC_CS_EXT_FALL 3'h6
`define TMC_CS_EXT_RISE 3'h7
// prescaler divide counts, minus one
`define TMC_DIV8_M1     10'h007
`define TMC_DIV64_M1    10'h03F
`define TMC_DIV256_M1   10'h0FF
`define TMC_DIV1024_M1  10'h3FF
// waveform modes
`define TMC_WGM_NORMAL  3'h0
`define TMC_WGM_PC_MAX  3'h1
`define TMC_WGM_CTC     3'h2
`define TMC_WGM_FP_MAX  3'h3
`define TMC_WGM_PC_OCR  3'h5
`define TMC_WGM_FP_OCR  3'h7
`define TMC_MAX         8'hFF
`endif

// file: hdl/tmc_timer.v
// Operation
// - each timer tick clears, increments or decrements the counter per mode.
// - the tick comes from the prescaled clock or the external pin per select.
// - a select of zero stops the tick so the counter holds its value.
// - software may read and write the counter whether or not ticks run.
// - a software counter write wins over a clear or count in that cycle.
// - three mode bits, two in control A and one in control B, pick the sequence.
// - the counter has an up/down direction and a clear forcing it to zero.
// - top is flagged at the mode's top value, the maximum or compare value a, and bottom at zero.
// - the overflow flag sets at the mode's point and can request an interrupt.
// - the counter is compared every cycle with both compare values.
// - a match sets its compare flag on the tick after the match.
// - an enabled set compare flag requests an interrupt and clears on service.
// - writing a one to a compare flag bit clears that flag.
// - each compare pin is formed from match, mode bits and its output select.
// - the waveform logic uses top and bottom for the extreme counter values.
`include "tmc_defines.vh"
module tmc_timer (
  input  wire        pclk,          // system clock
  input  wire        presetn,       // async reset, active low
  input  wire        psel,          // apb select
  input  wire        penable,       // apb enable
  input  wire        pwrite,        // apb direction
  input  wire [11:0] paddr,         // apb byte address
  input  wire [31:0] pwdata,        // apb write data
  output reg  [31:0] prdata,        // apb read data
  output reg         pready,        // apb ready
  output reg         pslverr,       // apb error, unmapped address
  input  wire        ext_tick_pin,  // external count pin, asynchronous
  input  wire        ack_ovf,       // overflow interrupt serviced
  input  wire        ack_cmp_a,     // compare a interrupt serviced
  input  wire        ack_cmp_b,     // compare b interrupt serviced
  output reg         irq_ovf,       // overflow interrupt request
  output reg         irq_cmp_a,     // compare a interrupt request
  output reg         irq_cmp_b,     // compare b interrupt request
  output reg         compare_pin_a, // waveform output a
  output reg         compare_pin_b  // waveform output b
);

  reg  [7:0] timer_control_a;
  reg  [7:0] timer_control_b;
  reg  [7:0] counter_value;
  reg  [7:0] compare_value_a;
  reg  [7:0] compare_value_b;
  reg  [2:0] int_mask;
  reg        overflow_flag;
  reg        compare_flag_a;
  reg        compare_flag_b;
  reg        count_down;
  reg  [9:0] prescale;
  reg        pin_sync1;
  reg        pin_sync2;
  reg        pin_last;

  wire [2:0] tick_source_select;
  wire [2:0] waveform_mode_bits;
  wire [1:0] compare_output_select_a;
  wire [1:0] compare_output_select_b;
  assign tick_source_select = timer_control_b[`TMC_CS_HI:`TMC_CS_LO];
  assign waveform_mode_bits = {timer_control_b[`TMC_WGM2_BIT],
                               timer_control_a[`TMC_WGM_HI:`TMC_WGM_LO]};
  assign compare_output_select_a =
    timer_control_a[`TMC_COM_A_HI:`TMC_COM_A_LO];
  assign compare_output_select_b =
    timer_control_a[`TMC_COM_B_HI:`TMC_COM_B_LO];

  // apb handshake
  wire setup_ph  = psel & ~penable;
  wire wr_commit = psel & penable & pready & pwrite;

  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `TMC_OFS_CTRL_A) || (a == `TMC_OFS_CTRL_B) ||
                  (a == `TMC_OFS_COUNT)  || (a == `TMC_OFS_CMP_A)  ||
                  (a == `TMC_OFS_CMP_B)  || (a == `TMC_OFS_MASK)   ||
                  (a == `TMC_OFS_FLAGS);
    end
  endfunction

  wire wr_ctrl_a = wr_commit && (paddr == `TMC_OFS_CTRL_A);
  wire wr_ctrl_b = wr_commit && (paddr == `TMC_OFS_CTRL_B);
  wire wr_count  = wr_commit && (paddr == `TMC_OFS_COUNT);
  wire wr_cmp_a  = wr_commit && (paddr == `TMC_OFS_CMP_A);
  wire wr_cmp_b  = wr_commit && (paddr == `TMC_OFS_CMP_B);
  wire wr_mask   = wr_commit && (paddr == `TMC_OFS_MASK);
  wire wr_flags  = wr_commit && (paddr == `TMC_OFS_FLAGS);

  // prescaler tap: the low bits of the free-running count are all ones;
  // the count is never cleared, so the first divided tick after a select
  // change may come at any phase of the divide period
  function div_hit;
    input [9:0] cnt;
    input [9:0] mask_m1;
    begin
      div_hit = ((cnt & mask_m1) == mask_m1);
    end
  endfunction

  // tick generation
  // pin_last resets low like an idle pin, so leaving reset makes no edge
  wire pin_rise = pin_sync2 & ~pin_last;
  wire pin_fall = ~pin_sync2 & pin_last;
  reg  timer_tick;
  always @* begin
    case (tick_source_select)
      `TMC_CS_STOP:     timer_tick = 1'b0;
      `TMC_CS_DIV1:     timer_tick = 1'b1;
      `TMC_CS_DIV8:     timer_tick = div_hit(prescale, `TMC_DIV8_M1);
      `TMC_CS_DIV64:    timer_tick = div_hit(prescale, `TMC_DIV64_M1);
      `TMC_CS_DIV256:   timer_tick = div_hit(prescale, `TMC_DIV256_M1);
      `TMC_CS_DIV1024:  timer_tick = div_hit(prescale, `TMC_DIV1024_M1);
      `TMC_CS_EXT_FALL: timer_tick = pin_fall;
      default:          timer_tick = pin_rise;
    endcase
  end

  // mode decode
  wire top_is_ocr = waveform_mode_bits[2] ||
                    (waveform_mode_bits == `TMC_WGM_CTC);
  wire [7:0] top_value = top_is_ocr ? compare_value_a : `TMC_MAX;
  wire mode_pc = (waveform_mode_bits == `TMC_WGM_PC_MAX) ||
                 (waveform_mode_bits == `TMC_WGM_PC_OCR);
  wire mode_fp = (waveform_mode_bits == `TMC_WGM_FP_MAX) ||
                 (waveform_mode_bits == `TMC_WGM_FP_OCR);
  wire mode_ctc = (waveform_mode_bits == `TMC_WGM_CTC);

  wire at_top    = (counter_value == top_value);
  wire at_max    = (counter_value == `TMC_MAX);
  wire at_bottom = (counter_value == `TMC_RST_BYTE);
  wire match_a   = (counter_value == compare_value_a);
  wire match_b   = (counter_value == compare_value_b);

  // counter next value
  reg [7:0] next_counter;
  reg       next_down;
  reg       ovf_event;
  always @* begin
    next_counter = counter_value;
    next_down    = count_down;
    ovf_event    = 1'b0;
    if (timer_tick) begin
      if (mode_pc) begin
        if (!count_down && at_top) begin
          next_down    = 1'b1;
          next_counter = counter_value - 8'h01;
        end else if (count_down && at_bottom) begin
          next_down    = 1'b0;
          next_counter = counter_value + 8'h01;
          ovf_event    = 1'b1;
        end else if (count_down) begin
          next_counter = counter_value - 8'h01;
        end else begin
          next_counter = counter_value + 8'h01;
        end
      end else if (mode_fp || mode_ctc) begin
        next_down = 1'b0;
        if (at_top) begin
          next_counter = `TMC_RST_BYTE;
        end else begin
          next_counter = counter_value + 8'h01;
        end
        ovf_event = mode_fp ? at_top : at_max;
      end else begin
        next_down    = 1'b0;
        next_counter = counter_value + 8'h01;
        ovf_event    = at_max;
      end
    end
    // a register write beats the tick update of the same edge
    if (wr_count) begin
      next_counter = pwdata[7:0];
    end
  end

  // waveform output per channel
  function wave_next;
    input       pin_now;
    input [1:0] com;
    input       match;
    input       tick;
    input       pc;
    input       fp;
    input       down;
    input       bottom;
    input       top;
    reg         r;
    begin
      r = pin_now;
      if (tick && com != 2'b00) begin
        if (fp) begin
          if (match && !top) begin
            r = com[0];
          end else if (top) begin
            r = ~com[0];
          end
        end else if (pc) begin
          if (match && !(bottom && down)) begin
            r = down ^ com[0];
          end
        end else if (match) begin
          if (com == 2'b01) begin
            r = ~pin_now;
          end else begin
            r = com[0];
          end
        end
      end
      wave_next = r;
    end
  endfunction

  function flag_next;
    input cur;
    input set_ev;
    input clr_ev;
    begin
      flag_next = set_ev | (cur & ~clr_ev);
    end
  endfunction

  // a service ack and a write-one clear act alike
  wire clr_ovf  = (wr_flags & pwdata[`TMC_BIT_OVF]) | ack_ovf;
  wire clr_cmpa = (wr_flags & pwdata[`TMC_BIT_CMPA]) | ack_cmp_a;
  wire clr_cmpb = (wr_flags & pwdata[`TMC_BIT_CMPB]) | ack_cmp_b;
  wire set_cmpa = timer_tick & match_a;
  wire set_cmpb = timer_tick & match_b;

  wire next_ovf_flag  = flag_next(overflow_flag, ovf_event, clr_ovf);
  wire next_cmpa_flag = flag_next(compare_flag_a, set_cmpa, clr_cmpa);
  wire next_cmpb_flag = flag_next(compare_flag_b, set_cmpb, clr_cmpb);

  reg [7:0] rd_mux;
  always @* begin
    rd_mux = `TMC_RST_BYTE;
    if (paddr == `TMC_OFS_CTRL_A) begin
      rd_mux = timer_control_a;
    end else if (paddr == `TMC_OFS_CTRL_B) begin
      rd_mux = timer_control_b;
    end else if (paddr == `TMC_OFS_COUNT) begin
      rd_mux = counter_value;
    end else if (paddr == `TMC_OFS_CMP_A) begin
      rd_mux = compare_value_a;
    end else if (paddr == `TMC_OFS_CMP_B) begin
      rd_mux = compare_value_b;
    end else if (paddr == `TMC_OFS_MASK) begin
      rd_mux = {5'h00, int_mask};
    end else if (paddr == `TMC_OFS_FLAGS) begin
      rd_mux = {5'h00, compare_flag_b, compare_flag_a, overflow_flag};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // zero wait states: ready follows every setup cycle
      pready <= setup_ph;
      if (setup_ph) begin
        prdata  <= {24'h00_0000, rd_mux};
        pslverr <= ~is_mapped(paddr);
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_a <= `TMC_RST_BYTE;
      timer_control_b <= `TMC_RST_BYTE;
      compare_value_a <= `TMC_RST_BYTE;
      compare_value_b <= `TMC_RST_BYTE;
      int_mask        <= `TMC_RST_FLAGS;
    end else begin
      if (wr_ctrl_a) begin
        timer_control_a <= pwdata[7:0];
      end
      if (wr_ctrl_b) begin
        timer_control_b <= {4'h0, pwdata[3:0]};
      end
      if (wr_cmp_a) begin
        compare_value_a <= pwdata[7:0];
      end
      if (wr_cmp_b) begin
        compare_value_b <= pwdata[7:0];
      end
      if (wr_mask) begin
        int_mask <= pwdata[2:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale  <= 10'h000;
      pin_sync1 <= 1'b0;
      pin_sync2 <= 1'b0;
      pin_last  <= 1'b0;
    end else begin
      prescale  <= prescale + 10'h001;
      // only the second stage reads the first
      pin_sync1 <= ext_tick_pin;
      pin_sync2 <= pin_sync1;
      pin_last  <= pin_sync2;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value  <= `TMC_RST_BYTE;
      count_down     <= 1'b0;
      overflow_flag  <= 1'b0;
      compare_flag_a <= 1'b0;
      compare_flag_b <= 1'b0;
      irq_ovf        <= 1'b0;
      irq_cmp_a      <= 1'b0;
      irq_cmp_b      <= 1'b0;
      compare_pin_a  <= 1'b0;
      compare_pin_b  <= 1'b0;
    end else begin
      counter_value  <= next_counter;
      count_down     <= next_down;
      // set wins over clear; zero bits leave flags alone
      overflow_flag  <= next_ovf_flag;
      compare_flag_a <= next_cmpa_flag;
      compare_flag_b <= next_cmpb_flag;
      irq_ovf   <= next_ovf_flag & int_mask[`TMC_BIT_OVF];
      irq_cmp_a <= next_cmpa_flag & int_mask[`TMC_BIT_CMPA];
      irq_cmp_b <= next_cmpb_flag & int_mask[`TMC_BIT_CMPB];
      compare_pin_a <= wave_next(compare_pin_a, compare_output_select_a,
                         match_a, timer_tick, mode_pc, mode_fp,
                         count_down, at_bottom, at_top);
      compare_pin_b <= wave_next(compare_pin_b, compare_output_select_b,
                         match_b, timer_tick, mode_pc, mode_fp,
                         count_down, at_bottom, at_top);
    end
  end

endmodule // tmc_timer

// file: dv/tmc_timer_checker.sv
module tmc_timer_checker (
  input logic        pclk,         // clock
  input logic        presetn,      // reset, active low
  input logic        psel,         // select
  input logic        penable,      // enable
  input logic [11:0] paddr,        // address
  input logic [31:0] prdata,       // read data
  input logic        pready,       // ready
  input logic        pslverr,      // error
  input logic        irq_ovf,      // overflow request
  input logic        compare_pin_a // waveform a
);
  timeunit 1ns;
  timeprecision 100ps;
  wire setup = psel && !penable;

  a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready) else $error("no ready after setup");
  a_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("ready held too long");
  a_ready_cause: assert property (@(posedge pclk) disable iff (!presetn)
    !setup |=> !pready) else $error("ready without setup");
  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    setup && paddr > 12'h018 |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
    setup && paddr <= 12'h018 && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("mapped access refused");
  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("error outside access");
  a_rdata_byte: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> prdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  a_reset_quiet: assert property (@(posedge pclk)
    !presetn |-> !pready && !irq_ovf && !compare_pin_a)
    else $error("output active in reset");

  c_unmapped: cover property (@(posedge pclk) setup ##1 pslverr);
  c_irq_ovf: cover property (@(posedge pclk) $rose(irq_ovf));
  c_pin_a: cover property (@(posedge pclk) $rose(compare_pin_a));
endmodule // tmc_timer_checker

bind tmc_timer tmc_timer_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq_ovf(irq_ovf),
  .compare_pin_a(compare_pin_a));

// file: dv/tmc_timer_tb.sv
`include "tmc_defines.vh"
module tmc_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  logic        ext = 0, ack_ovf = 0, ack_a = 0, ack_b = 0, e;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq_ovf, irq_a, irq_b, pin_a, pin_b;
  logic [7:0]  mx;
  int          err_total = 0, n_compared = 0, cyc = 0, seed = 32'hd17b;
  int          i, s, d;

  always #12.5 pclk = ~pclk;

  tmc_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_tick_pin(ext), .ack_ovf(ack_ovf), .ack_cmp_a(ack_a),
    .ack_cmp_b(ack_b), .irq_ovf(irq_ovf), .irq_cmp_a(irq_a),
    .irq_cmp_b(irq_b), .compare_pin_a(pin_a), .compare_pin_b(pin_b));

  task stop_test;
    $display("compared %0d, failed %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // exact when tolerance is zero; x bits always fail
  task chk(input logic [31:0] g, input logic [31:0] x, input int t = 0);
    n_compared++;
    if (^g === 1'bx || g + t < x || g > x + t) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task apb(input logic [11:0] a, input logic w, input logic [31:0] v);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= v;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) chk(32'(pready), 1);
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      stop_test;
    end
  end

  initial begin
    // a real falling edge, so the asynchronous reset acts at time zero
    presetn <= 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (i = 0; i < 7; i++) begin
      apb(12'(i * 4), 0, 0);
      chk(rd, 0);
    end
    apb(12'h01C, 1, 32'h0000_00FF);
    chk({rd[30:0], e}, 1);
    for (i = 0; i < 8; i++) begin
      s = $random(seed);
      apb(`TMC_OFS_COUNT, 1, s);
      repeat (s[3:0]) @(posedge pclk);
      apb(`TMC_OFS_COUNT, 0, 0);
      chk(rd, s & 32'hFF);
      apb(`TMC_OFS_CMP_A + 12'(i % 2 * 4), 1, ~s);
      apb(`TMC_OFS_CMP_A + 12'(i % 2 * 4), 0, 0);
      chk(rd, ~s & 32'hFF);
    end
    $display("test registers done");
    for (s = 1; s < 6; s++) begin
      d = (s == 1) ? 1 : (s == 2) ? `TMC_DIV8_M1 + 1 :
          (s == 3) ? `TMC_DIV64_M1 + 1 :
          (s == 4) ? `TMC_DIV256_M1 + 1 : `TMC_DIV1024_M1 + 1;
      apb(`TMC_OFS_COUNT, 1, 0);
      apb(`TMC_OFS_CTRL_B, 1, s);
      repeat (3 * d) @(posedge pclk);
      apb(`TMC_OFS_CTRL_B, 1, 0);
      apb(`TMC_OFS_COUNT, 0, 0);
      chk(rd, (3 * d + 3) / d, 2);
    end
    for (s = 6; s < 8; s++) begin
      apb(`TMC_OFS_COUNT, 1, 8'h10);
      apb(`TMC_OFS_CTRL_B, 1, s);
      repeat (5) begin
        ext <= 1;
        repeat (4) @(posedge pclk);
        ext <= 0;
        repeat (4) @(posedge pclk);
      end
      apb(`TMC_OFS_CTRL_B, 1, 0);
      apb(`TMC_OFS_COUNT, 0, 0);
      chk(rd, 8'h15);
    end
    $display("test tick sources done");
    apb(`TMC_OFS_CMP_A, 1, 8'h10);
    for (s = 0; s < 8; s++) begin
      apb(`TMC_OFS_CTRL_B, 1, 0);
      apb(`TMC_OFS_COUNT, 1, 0);
      apb(`TMC_OFS_CTRL_A, 1, s & 3);
      apb(`TMC_OFS_CTRL_B, 1, (s & 4) << 1 | 1);
      mx = 0;
      repeat (16) begin
        repeat ($random(seed) & 7) @(posedge pclk);
        apb(`TMC_OFS_COUNT, 0, 0);
        if (rd[7:0] > mx) mx = rd[7:0];
      end
      chk(32'(mx <= 8'h10), 32'(s == 2 || s == 5 || s == 7));
    end
    $display("test modes done");
    apb(`TMC_OFS_CTRL_B, 1, 0);
    apb(`TMC_OFS_CTRL_A, 1, 8'h70);
    apb(`TMC_OFS_CMP_A, 1, 8'h05);
    apb(`TMC_OFS_CMP_B, 1, 8'h03);
    apb(`TMC_OFS_FLAGS, 1, 7);
    apb(`TMC_OFS_COUNT, 1, 8'hFE);
    apb(`TMC_OFS_CTRL_B, 1, 1);
    repeat (12) @(posedge pclk);
    apb(`TMC_OFS_CTRL_B, 1, 0);
    apb(`TMC_OFS_FLAGS, 0, 0);
    chk(rd, 7);
    chk({pin_b, pin_a}, 2'b11);
    apb(`TMC_OFS_FLAGS, 1, 0);
    apb(`TMC_OFS_FLAGS, 0, 0);
    chk(rd, 7);
    apb(`TMC_OFS_MASK, 1, 7);
    repeat (2) @(posedge pclk);
    chk({irq_b, irq_a, irq_ovf}, 3'b111);
    ack_ovf <= 1;
    @(posedge pclk);
    ack_ovf <= 0;
    repeat (2) @(posedge pclk);
    chk({irq_b, irq_a, irq_ovf}, 3'b110);
    apb(`TMC_OFS_FLAGS, 1, 2);
    apb(`TMC_OFS_FLAGS, 0, 0);
    chk(rd, 4);
    ack_b <= 1;
    @(posedge pclk);
    ack_b <= 0;
    repeat (2) @(posedge pclk);
    chk({irq_b, irq_a, irq_ovf}, 3'b000);
    apb(`TMC_OFS_COUNT, 1, 8'h04);
    apb(`TMC_OFS_CTRL_B, 1, 1);
    apb(`TMC_OFS_CTRL_B, 1, 0);
    chk({irq_a, pin_a}, 2'b10);
    ack_a <= 1;
    @(posedge pclk);
    ack_a <= 0;
    apb(`TMC_OFS_FLAGS, 0, 0);
    chk({irq_a, rd[2:0]}, 4'h0);
    $display("test flags done");
    apb(`TMC_OFS_CTRL_A, 1, 8'h83);
    apb(`TMC_OFS_CMP_A, 1, 8'h80);
    apb(`TMC_OFS_COUNT, 1, 8'hF0);
    for (i = 0; i < 4; i++) begin
      apb(`TMC_OFS_CTRL_B, 1, 1);
      repeat (20 + ($random(seed) & 255)) @(posedge pclk);
      apb(`TMC_OFS_CTRL_B, 1, 0);
      apb(`TMC_OFS_COUNT, 0, 0);
      // clear on match, set at top: high from 00 up to the compare value
      chk(pin_a, rd[7:0] <= 8'h80);
    end
    $display("test fast waveform done");
    apb(`TMC_OFS_CTRL_B, 1, 1);
    apb(`TMC_OFS_COUNT, 1, 8'h40);
    apb(`TMC_OFS_CTRL_B, 1, 0);
    apb(`TMC_OFS_COUNT, 0, 0);
    chk(rd, 8'h43, 2);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(`TMC_OFS_COUNT, 0, 0);
    chk(rd, 0);
    $display("test write priority and reset done");
    stop_test;
  end
endmodule // tmc_timer_tb
